// ==== common/scm_pkg.sv ====
package scm_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the apb bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_RESP = 8'h04;
  localparam logic [7:0] OFF_PWR = 8'h08;
  localparam logic [7:0] OFF_PRD = 8'h0C;
  localparam logic [7:0] OFF_RATE = 8'h10;
  localparam logic [7:0] OFF_SADDR = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;

  // ----------------------------------------------------------------
  // opcodes and opcode groups
  // ----------------------------------------------------------------
  localparam logic [2:0] OPG_MISC = 3'h0;
  localparam logic [2:0] OPG_FETCH = 3'h4;
  localparam logic [2:0] OPG_STORE = 3'h5;
  localparam logic [2:0] OPG_CLR = 3'h6;
  localparam logic [2:0] OPG_SET = 3'h7;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_RESET = 8'h01;
  localparam logic [7:0] OP_ADDR = 8'h02;
  localparam logic [7:0] OP_PROX_SINGLE = 8'h05;
  localparam logic [7:0] OP_AMB_SINGLE = 8'h06;
  localparam logic [7:0] OP_BOTH_SINGLE = 8'h07;
  localparam logic [7:0] OP_PROX_PAUSE = 8'h09;
  localparam logic [7:0] OP_AMB_PAUSE = 8'h0A;
  localparam logic [7:0] OP_BOTH_PAUSE = 8'h0B;
  localparam logic [7:0] OP_PROX_LOOP = 8'h0D;
  localparam logic [7:0] OP_AMB_LOOP = 8'h0E;
  localparam logic [7:0] OP_BOTH_LOOP = 8'h0F;

  // ----------------------------------------------------------------
  // response codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESP_CLEAR = 8'h00;
  localparam logic [7:0] RESP_INVALID = 8'h80;
  localparam logic [7:0] RESP_PROX1_OVF = 8'h88;
  localparam logic [7:0] RESP_PROX2_OVF = 8'h89;
  localparam logic [7:0] RESP_PROX3_OVF = 8'h8A;
  localparam logic [7:0] RESP_VIS_OVF = 8'h8C;
  localparam logic [7:0] RESP_IR_OVF = 8'h8D;
  localparam logic [7:0] RESP_AUX_OVF = 8'h8E;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] PARAM_RST = 8'h00;
  localparam logic [6:0] SADDR_RST = 7'h2A;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } scm_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scm_apb_rsp_s;

  typedef struct packed {
    logic start;
    logic [1:0] kind;
    logic loop_prox;
    logic loop_amb;
  } scm_meas_ctl_s;

  typedef struct packed {
    logic done;
    logic [2:0] ovf_chan;
  } scm_meas_res_s;

  typedef enum logic [1:0] {ST_STANDBY, ST_EXEC, ST_MEAS} scm_state_e;

endpackage

// ==== rtl/scm_mailbox.sv ====
`timescale 1ns/1ps
// Function
// - only a command register write wakes the sequencer; other writes just store
// - error-free completion gives zero upper nibble and a wrapping 4-bit count
// - non-zero upper nibble marks an error or special condition
// - firmware reset does not count; host waits 1 ms before next command
// - group 100 fetches the addressed parameter into the read mailbox
// - group 101 stores the write mailbox into the parameter, echoes it
// - group 110 ands the write mailbox into the parameter, returns result
// - group 111 ors the write mailbox into the parameter, returns result
// - no-operation forces the response to zero, clearing count and error
// - opcode 01 resets the firmware state to defaults; the bus address keeps its value
// - three opcodes force one proximity, ambient or combined measurement
// - three opcodes start or restart the autonomous measurement loops
// - count increments under zero upper nibble, cleared only by no-operation or firmware reset
// - invalid setting loads its code, held until no-operation or firmware reset
// - proximity channel overflows report their matching codes
// - visible, infrared and auxiliary overflows report their matching codes
// - write and read mailbox registers carry parameter data
// - parameter memory reachable only through commands, not mapped
// - with zero wakeup interval the loops stay off, forced mode only
module scm_mailbox #(
  parameter int PARAM_DEPTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire scm_pkg::scm_apb_req_s apb_req_in,
  output scm_pkg::scm_apb_rsp_s apb_rsp_out,
  input wire scm_pkg::scm_meas_res_s meas_res_in,
  output scm_pkg::scm_meas_ctl_s meas_ctl_out,
  output logic [6:0] slave_addr_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // completion count, frozen while an error code is latched
  function automatic logic [7:0] count_up(input logic [7:0] r);
    count_up = (r[7:4] == 4'h0) ? {4'h0, 4'(r[3:0] + 4'h1)} : r;
  endfunction

  // overflow channel to response code, zero when no overflow
  function automatic logic [7:0] ovf_code(input logic [2:0] ch);
    case (ch)
      3'h1: ovf_code = scm_pkg::RESP_PROX1_OVF;
      3'h2: ovf_code = scm_pkg::RESP_PROX2_OVF;
      3'h3: ovf_code = scm_pkg::RESP_PROX3_OVF;
      3'h4: ovf_code = scm_pkg::RESP_VIS_OVF;
      3'h5: ovf_code = scm_pkg::RESP_IR_OVF;
      3'h6: ovf_code = scm_pkg::RESP_AUX_OVF;
      default: ovf_code = scm_pkg::RESP_CLEAR;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  scm_pkg::scm_state_e state;
  scm_pkg::scm_state_e next_state;
  logic [7:0] opcode;
  logic [7:0] resp;
  logic [7:0] next_resp;
  logic [7:0] wr_mbox;
  logic [7:0] rd_mbox;
  logic [7:0] next_rd;
  logic [7:0] rate;
  logic [6:0] saddr;
  logic loop_prox;
  logic loop_amb;
  logic next_loop_prox;
  logic next_loop_amb;
  logic meas_start;
  logic [1:0] meas_kind;
  logic [7:0] prdata;
  logic pslverr;
  // parameter memory has no bus address at all
  logic [7:0] param_ram [PARAM_DEPTH];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = apb_req_in.psel & ~apb_req_in.penable;
  wire access = apb_req_in.psel & apb_req_in.penable;
  wire wr_acc = access & apb_req_in.pwrite;
  wire [7:0] wdata = apb_req_in.pwdata[7:0];
  wire hit_cmd = apb_req_in.paddr == scm_pkg::OFF_CMD;
  wire hit_pwr = apb_req_in.paddr == scm_pkg::OFF_PWR;
  wire hit_rate = apb_req_in.paddr == scm_pkg::OFF_RATE;
  wire mapped = hit_cmd | hit_pwr | hit_rate
      | (apb_req_in.paddr == scm_pkg::OFF_RESP)
      | (apb_req_in.paddr == scm_pkg::OFF_PRD)
      | (apb_req_in.paddr == scm_pkg::OFF_SADDR)
      | (apb_req_in.paddr == scm_pkg::OFF_STAT);
  // a command written while busy is dropped; host polling prevents it
  wire cmd_wr = wr_acc & hit_cmd & (state == scm_pkg::ST_STANDBY);
  wire pwr_wr = wr_acc & hit_pwr;
  wire rate_wr = wr_acc & hit_rate;
  wire [7:0] stat_val = {4'h0, state != scm_pkg::ST_STANDBY, loop_amb, loop_prox,
                         rate == scm_pkg::RATE_RST};

  // read mux, sampled in the setup cycle so prdata comes from a flop
  wire [7:0] rd_sel = (apb_req_in.paddr == scm_pkg::OFF_RESP) ? resp :
                      (apb_req_in.paddr == scm_pkg::OFF_PWR) ? wr_mbox :
                      (apb_req_in.paddr == scm_pkg::OFF_PRD) ? rd_mbox :
                      (apb_req_in.paddr == scm_pkg::OFF_RATE) ? rate :
                      (apb_req_in.paddr == scm_pkg::OFF_SADDR) ? {1'b0, saddr} :
                      (apb_req_in.paddr == scm_pkg::OFF_STAT) ? stat_val :
                      8'h00;

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  wire exec = state == scm_pkg::ST_EXEC;
  wire [2:0] op_grp = opcode[7:5];
  wire [4:0] op_idx = opcode[4:0];
  wire [7:0] pval = param_ram[op_idx];
  wire is_param = op_grp != scm_pkg::OPG_MISC;
  wire is_nop = opcode == scm_pkg::OP_NOP;
  wire is_rst = opcode == scm_pkg::OP_RESET;
  wire is_addr = opcode == scm_pkg::OP_ADDR;
  wire is_single = (opcode == scm_pkg::OP_PROX_SINGLE) | (opcode == scm_pkg::OP_AMB_SINGLE)
      | (opcode == scm_pkg::OP_BOTH_SINGLE);
  wire is_pause = (opcode == scm_pkg::OP_PROX_PAUSE) | (opcode == scm_pkg::OP_AMB_PAUSE)
      | (opcode == scm_pkg::OP_BOTH_PAUSE);
  wire is_loop = (opcode == scm_pkg::OP_PROX_LOOP) | (opcode == scm_pkg::OP_AMB_LOOP)
      | (opcode == scm_pkg::OP_BOTH_LOOP);
  wire soft_rst = exec & is_rst;
  wire ram_we = exec & is_param & (op_grp != scm_pkg::OPG_FETCH);
  // a loop with no wakeup interval cannot run, so it is an invalid setting
  wire loop_bad = is_loop & (rate == scm_pkg::RATE_RST);

  // updated parameter value per group
  wire [7:0] pnew = (op_grp == scm_pkg::OPG_STORE) ? wr_mbox :
                    (op_grp == scm_pkg::OPG_CLR) ? (pval & wr_mbox) :
                    (op_grp == scm_pkg::OPG_SET) ? (pval | wr_mbox) :
                    pval;

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_resp = resp;
    next_rd = rd_mbox;
    next_loop_prox = loop_prox;
    next_loop_amb = loop_amb;
    case (state)
      scm_pkg::ST_STANDBY: begin
        if (cmd_wr) begin
          next_state = scm_pkg::ST_EXEC;
        end
      end
      scm_pkg::ST_EXEC: begin
        next_state = scm_pkg::ST_STANDBY;
        if (is_param) begin
          next_rd = pnew;
          next_resp = count_up(resp);
        end else if (is_nop) begin
          next_resp = scm_pkg::RESP_CLEAR;
        end else if (is_rst) begin
          // no count here: the host does not poll after a reset
          next_resp = scm_pkg::RESP_CLEAR;
          next_rd = scm_pkg::PARAM_RST;
          next_loop_prox = 1'b0;
          next_loop_amb = 1'b0;
        end else if (is_addr) begin
          next_resp = count_up(resp);
        end else if (is_single) begin
          next_state = scm_pkg::ST_MEAS;
        end else if (is_pause) begin
          next_loop_prox = loop_prox & ~opcode[0];
          next_loop_amb = loop_amb & ~opcode[1];
          next_resp = count_up(resp);
        end else if (loop_bad) begin
          next_resp = (resp[7:4] == 4'h0) ? scm_pkg::RESP_INVALID : resp;
        end else if (is_loop) begin
          next_loop_prox = loop_prox | opcode[0];
          next_loop_amb = loop_amb | opcode[1];
          next_resp = count_up(resp);
        end
        // reserved group 000 opcodes fall through untouched; groups 001 to 011 run as a counted fetch
      end
      scm_pkg::ST_MEAS: begin
        if (meas_res_in.done) begin
          next_state = scm_pkg::ST_STANDBY;
          if (resp[7:4] != 4'h0) begin
            next_resp = resp;
          end else if (meas_res_in.ovf_chan != 3'h0) begin
            next_resp = ovf_code(meas_res_in.ovf_chan);
          end else begin
            next_resp = count_up(resp);
          end
        end
      end
      default: begin
        next_state = scm_pkg::ST_STANDBY;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  // opcode latched from the bus on the waking write
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= scm_pkg::ST_STANDBY;
      opcode <= scm_pkg::OP_NOP;
      resp <= scm_pkg::RESP_CLEAR;
      rd_mbox <= scm_pkg::PARAM_RST;
    end else begin
      state <= next_state;
      opcode <= cmd_wr ? wdata : opcode;
      resp <= next_resp;
      rd_mbox <= next_rd;
    end
  end

  // loops and the one-cycle measurement start
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      loop_prox <= 1'b0;
      loop_amb <= 1'b0;
      meas_start <= 1'b0;
      meas_kind <= 2'h0;
    end else begin
      loop_prox <= next_loop_prox;
      loop_amb <= next_loop_amb;
      meas_start <= exec & is_single;
      meas_kind <= (exec & is_single) ? opcode[1:0] : meas_kind;
    end
  end

  // host-writable storage; firmware reset restores the wr_mbox and rate defaults, saddr keeps its value
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_mbox <= scm_pkg::PARAM_RST;
      rate <= scm_pkg::RATE_RST;
      saddr <= scm_pkg::SADDR_RST;
    end else begin
      wr_mbox <= soft_rst ? scm_pkg::PARAM_RST : (pwr_wr ? wdata : wr_mbox);
      rate <= soft_rst ? scm_pkg::RATE_RST : (rate_wr ? wdata : rate);
      saddr <= (exec & is_addr) ? wr_mbox[6:0] : saddr;
    end
  end

  // parameter memory, written only by the sequencer
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < PARAM_DEPTH; i++) begin
        param_ram[i] <= scm_pkg::PARAM_RST;
      end
    end else begin
      for (int i = 0; i < PARAM_DEPTH; i++) begin
        if (soft_rst) begin
          param_ram[i] <= scm_pkg::PARAM_RST;
        end else if (ram_we && op_idx == 5'(i)) begin
          param_ram[i] <= pnew;
        end
      end
    end
  end

  // bus read data and error, captured in setup so access is single-cycle
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata <= 8'h00;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= rd_sel;
      pslverr <= ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_rsp_out.pready = 1'b1;
  assign apb_rsp_out.pslverr = pslverr & access;
  assign apb_rsp_out.prdata = {24'h000000, prdata};
  assign meas_ctl_out.start = meas_start;
  assign meas_ctl_out.kind = meas_kind;
  // loops only run with a non-zero interval; otherwise forced mode
  assign meas_ctl_out.loop_prox = loop_prox & (rate != scm_pkg::RATE_RST);
  assign meas_ctl_out.loop_amb = loop_amb & (rate != scm_pkg::RATE_RST);
  assign slave_addr_out = saddr;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_cmd_write;
    wr_acc && hit_cmd && state == scm_pkg::ST_STANDBY;
  endsequence

  sequence seq_run(logic [7:0] op);
    exec && opcode == op;
  endsequence

  chk_cmd_wakes: assert property (seq_cmd_write |=> exec && opcode == $past(wdata))
    else $error("command write did not wake the sequencer");
  chk_other_sleeps: assert property (wr_acc && !hit_cmd && state == scm_pkg::ST_STANDBY
      |=> state == scm_pkg::ST_STANDBY)
    else $error("non-command write woke the sequencer");
  chk_count_wraps: assert property (exec && is_param && resp[7:4] == 4'h0
      |=> resp[7:4] == 4'h0 && resp[3:0] == 4'($past(resp[3:0]) + 4'h1))
    else $error("completion count did not advance");
  chk_nop_clears: assert property (seq_run(scm_pkg::OP_NOP) |=> resp == 8'h00)
    else $error("no-operation did not clear response");
  chk_reset_quiet: assert property (seq_run(scm_pkg::OP_RESET)
      |=> resp == 8'h00 && rate == scm_pkg::RATE_RST && !loop_prox && !loop_amb)
    else $error("firmware reset left state behind");
  chk_fetch_mailbox: assert property (exec && op_grp == scm_pkg::OPG_FETCH
      |=> rd_mbox == $past(pval))
    else $error("fetch did not return parameter");
  chk_store_echo: assert property (exec && op_grp == scm_pkg::OPG_STORE
      |=> rd_mbox == $past(wr_mbox) ##1 param_ram[$past(op_idx, 2)] == rd_mbox)
    else $error("store did not reach parameter");
  chk_error_sticky: assert property (resp[7:4] != 4'h0 && !(exec && (is_nop || is_rst))
      |=> resp == $past(resp))
    else $error("error code changed without no-operation");
  chk_force_start: assert property (exec && is_single
      |=> meas_start && state == scm_pkg::ST_MEAS ##1 !meas_start)
    else $error("forced measurement not started once");
  chk_ovf_report: assert property (state == scm_pkg::ST_MEAS && meas_res_in.done
      && meas_res_in.ovf_chan == 3'h1 && resp[7:4] == 4'h0 |=> resp == 8'h88)
    else $error("overflow code not reported");
  chk_loop_gated: assert property (rate == scm_pkg::RATE_RST
      |-> !meas_ctl_out.loop_prox && !meas_ctl_out.loop_amb)
    else $error("loop running with zero interval");
  chk_pause_counts: assert property (exec && is_pause && resp[7:4] == 4'h0
      |=> resp[3:0] == 4'($past(resp[3:0]) + 4'h1) && !(loop_prox && $past(opcode[0])))
    else $error("pause did not count or stop its loop");
  // the new address comes from the write mailbox and never raises an error
  chk_addr_taken: assert property (exec && is_addr
      |=> slave_addr_out == $past(wr_mbox[6:0]) && resp[7:4] == $past(resp[7:4]))
    else $error("address change not taken or raised an error");

endmodule // scm_mailbox

// ==== sim/scm_meas_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// measurement datapath stand-in
// ----------------------------------------------------------------
module scm_meas_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire scm_pkg::scm_meas_ctl_s ctl_in,
  input wire logic [3:0] delay_in,
  input wire logic [2:0] ovf_in,
  output scm_pkg::scm_meas_res_s res_out
);
  logic [4:0] left;
  logic [2:0] churn;
  // busy countdown after each start; the channel lines churn whenever done is low
  // so a design that samples them outside done sees garbage, not a stale code
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left <= 5'h00;
      churn <= 3'h0;
    end else begin
      churn <= churn + 3'h1;
      if (ctl_in.start) begin
        left <= {1'b0, delay_in} + 5'h01;
      end else if (left != 5'h00) begin
        left <= left - 5'h01;
      end
    end
  end
  // done is a one-cycle pulse carrying the chosen overflow channel
  assign res_out.done = (left == 5'h01);
  assign res_out.ovf_chan = (left == 5'h01) ? ovf_in : churn;
endmodule // scm_meas_model

// ==== sim/scm_mailbox_test.sv ====
`timescale 1ns/1ps
module scm_mailbox_test;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] wd;
    logic [7:0] resp;
    logic [7:0] prd;
  } scm_row_s;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  scm_pkg::scm_apb_req_s req = '0;
  scm_pkg::scm_apb_rsp_s rsp;
  scm_pkg::scm_meas_res_s res;
  scm_pkg::scm_meas_ctl_s ctl;
  logic [6:0] saddr;
  logic [3:0] mdelay = 4'h4;
  logic [2:0] movf = 3'h0;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] r;
  int mismatches = 0;
  int checks_done = 0;
  // host gives up on a silent command after 25 ms and starts over
  localparam longint RESTART_NS = 25000000;
  // opcode, write mailbox, expected response, expected read mailbox
  scm_row_s rows [13] = '{32'hA35A015A, 32'h8300015A, 32'hC30F010A, 32'hE3F001FA,
    32'hBF810181, 32'h9F000181, 32'h830001FA, 32'h0D0080FA, 32'h0E0080FA,
    32'h0F0080FA, 32'h050001FA, 32'h060001FA, 32'h070001FA};
  logic [7:0] ovf_codes [6] = '{scm_pkg::RESP_PROX1_OVF, scm_pkg::RESP_PROX2_OVF,
    scm_pkg::RESP_PROX3_OVF, scm_pkg::RESP_VIS_OVF, scm_pkg::RESP_IR_OVF,
    scm_pkg::RESP_AUX_OVF};
  logic [7:0] resv [6] = '{8'h03, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1F};

  scm_mailbox #(.PARAM_DEPTH(32)) dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .apb_req_in(req), .apb_rsp_out(rsp), .meas_res_in(res), .meas_ctl_out(ctl),
    .slave_addr_out(saddr));
  scm_meas_model mdl_u (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ctl_in(ctl),
    .delay_in(mdelay), .ovf_in(movf), .res_out(res));

  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // one setup and one access phase; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge ref_clk_in);
    req.penable <= 1'b1;
    // no cycle limit here: only the watchdog may end a stuck wait
    do begin
      @(posedge ref_clk_in);
    end while (rsp.pready !== 1'b1);
    chk(rsp.pready, 32'h1, "ready");
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // full host sequence: clear, confirm zero, issue, poll until non-zero
  task automatic cmd(input logic [7:0] op, input logic [7:0] wd, output logic [7:0] rv);
    longint t0;
    int tries;
    tries = 0;
    do begin
      wr(scm_pkg::OFF_PWR, {24'h0, wd});
      wr(scm_pkg::OFF_CMD, 32'h0);
      rd(scm_pkg::OFF_RESP);
      chk(rdat, 32'h0, "cleared response");
      wr(scm_pkg::OFF_CMD, {24'h0, op});
      t0 = $time;
      do begin
        rd(scm_pkg::OFF_RESP);
      end while (rdat[7:0] == 8'h00 && ($time - t0) <= RESTART_NS);
      tries++;
    end while (rdat[7:0] == 8'h00 && tries < 2);
    rv = rdat[7:0];
  endtask

  task automatic wait_resp();
    repeat (3) @(posedge ref_clk_in);
    rd(scm_pkg::OFF_RESP);
  endtask

  task automatic fin(input string name);
    $display("test %s finished", name);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog, about twice the expected run
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].wd, r);
      chk(r, rows[i].resp, "response");
      rd(scm_pkg::OFF_PRD);
      chk(rdat, rows[i].prd, "read mailbox");
      if (rows[i].op inside {8'h05, 8'h06, 8'h07}) chk(ctl.kind, rows[i].op[1:0], "kind");
    end
    fin("table");
    // plain register traffic must not wake the sequencer
    wr(scm_pkg::OFF_PWR, 32'h3C);
    wr(scm_pkg::OFF_RATE, 32'h0);
    rd(scm_pkg::OFF_PWR);
    chk(rdat, 32'h3C, "write mailbox");
    rd(scm_pkg::OFF_RESP);
    chk(rdat, 32'h1, "no wake");
    rd(scm_pkg::OFF_CMD);
    chk(rdat, 32'h0, "command reads zero");
    rd(8'h1C);
    chk(rerr, 32'h1, "unmapped error");
    chk(rdat, 32'h0, "unmapped data");
    fin("registers");
    // counter wraps without any clearing in between
    wr(scm_pkg::OFF_CMD, 32'h0);
    for (int i = 1; i <= 17; i++) begin
      wr(scm_pkg::OFF_CMD, 32'h83);
      wait_resp();
      chk(rdat, i % 16, "count");
    end
    fin("wrap");
    for (int i = 0; i < 6; i++) begin
      movf <= 3'(i + 1);
      cmd(scm_pkg::OP_PROX_SINGLE, 8'h00, r);
      chk(r, ovf_codes[i], "overflow code");
    end
    // error code must survive a later good command
    wr(scm_pkg::OFF_CMD, 32'h83);
    wait_resp();
    chk(rdat, scm_pkg::RESP_AUX_OVF, "sticky error");
    movf <= 3'h0;
    fin("overflow");
    wr(scm_pkg::OFF_CMD, 32'h0);
    foreach (resv[i]) begin
      wr(scm_pkg::OFF_CMD, {24'h0, resv[i]});
      wait_resp();
      chk(rdat, 32'h0, "reserved ignored");
    end
    fin("reserved");
    wr(scm_pkg::OFF_RATE, 32'h1);
    cmd(scm_pkg::OP_PROX_LOOP, 8'h00, r);
    chk(r, 32'h1, "prox loop resp");
    chk(ctl.loop_prox, 32'h1, "prox loop");
    cmd(scm_pkg::OP_AMB_LOOP, 8'h00, r);
    chk(ctl.loop_amb, 32'h1, "amb loop");
    cmd(scm_pkg::OP_BOTH_LOOP, 8'h00, r);
    rd(scm_pkg::OFF_STAT);
    chk(rdat[2:0], 32'h6, "loop status");
    // pauses stop only their own loop and still count
    cmd(scm_pkg::OP_PROX_PAUSE, 8'h00, r);
    chk(r, 32'h1, "pause resp");
    chk({ctl.loop_prox, ctl.loop_amb}, 32'h1, "prox paused");
    cmd(scm_pkg::OP_BOTH_PAUSE, 8'h00, r);
    chk({ctl.loop_prox, ctl.loop_amb}, 32'h0, "both paused");
    cmd(scm_pkg::OP_AMB_LOOP, 8'h00, r);
    cmd(scm_pkg::OP_AMB_PAUSE, 8'h00, r);
    chk(ctl.loop_amb, 32'h0, "amb paused");
    cmd(scm_pkg::OP_BOTH_LOOP, 8'h00, r);
    chk({ctl.loop_prox, ctl.loop_amb}, 32'h3, "loops back on");
    fin("loops");
    cmd(scm_pkg::OP_ADDR, 8'h33, r);
    chk(r, 32'h1, "address resp");
    chk(saddr, 32'h33, "new address");
    fin("address");
    // firmware reset straight after a counted command
    cmd(8'h83, 8'h00, r);
    wr(scm_pkg::OFF_CMD, {24'h0, scm_pkg::OP_RESET});
    wait_resp();
    chk(rdat, 32'h0, "reset not counted");
    chk({ctl.loop_prox, ctl.loop_amb}, 32'h0, "loops off");
    repeat (50000) @(posedge ref_clk_in);
    rd(scm_pkg::OFF_RATE);
    chk(rdat, 32'h0, "rate default");
    cmd(8'h83, 8'h00, r);
    rd(scm_pkg::OFF_PRD);
    chk(rdat, 32'h0, "param default");
    fin("firmware reset");
    rst_n_in <= 1'b0;
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    chk(saddr, scm_pkg::SADDR_RST, "address default");
    rd(scm_pkg::OFF_RESP);
    chk(rdat, 32'h0, "response default");
    rd(scm_pkg::OFF_STAT);
    chk(rdat[3:0], 32'h1, "status default");
    fin("hardware reset");
    print_verdict();
  end
endmodule // scm_mailbox_test
